// file: core/psri_pkg.sv
// psri_pkg: register map, field layout, reset values, timing and state codes
// of the pressure sensor register interface.
// assumes a 40 MHz system clock; all users import the whole package.
package psri_pkg;

  // two-wire serial bus target address
  localparam logic [6:0] PSRI_TARGET_ADDR = 7'h7f;

  // register offsets
  localparam logic [7:0] PSRI_OFF_PRESS_HIGH = 8'h06;
  localparam logic [7:0] PSRI_OFF_PRESS_MID  = 8'h07;
  localparam logic [7:0] PSRI_OFF_PRESS_LOW  = 8'h08;
  localparam logic [7:0] PSRI_OFF_TEMP_HIGH  = 8'h09;
  localparam logic [7:0] PSRI_OFF_TEMP_LOW   = 8'h0a;
  localparam logic [7:0] PSRI_OFF_CMD        = 8'h30;
  localparam logic [7:0] PSRI_OFF_SYSCFG     = 8'ha5;
  localparam logic [7:0] PSRI_OFF_PCFG       = 8'ha6;

  // measurement_command fields
  localparam int         PSRI_CMD_SLEEP_LSB = 4;
  localparam int         PSRI_CMD_START_BIT = 3;
  localparam logic [2:0] PSRI_MODE_COMBINED = 3'h2;
  localparam logic [2:0] PSRI_MODE_SLEEP    = 3'h3;

  // system_configuration fields
  localparam int PSRI_SYS_REG_BIT  = 3;
  localparam int PSRI_SYS_UNS_BIT  = 2;
  localparam int PSRI_SYS_RAW_BIT  = 1;
  localparam int PSRI_SYS_DIAG_BIT = 0;

  // pressure_channel_configuration fields
  localparam int PSRI_PCFG_SWAP_BIT = 7;
  localparam int PSRI_PCFG_GAIN_LSB = 3;

  // values after reset
  localparam logic [7:0]  PSRI_CMD_RST    = 8'h00;
  localparam logic [7:0]  PSRI_SYSCFG_RST = 8'h01;
  localparam logic [7:0]  PSRI_PCFG_RST   = 8'h00;
  localparam logic [23:0] PSRI_PRESS_RST  = 24'h000000;
  localparam logic [15:0] PSRI_TEMP_RST   = 16'h0000;

  // sleep interval step: 62.5 ms per code step at 40 MHz
  localparam int PSRI_CLK_FREQ_KHZ  = 40000;
  localparam int PSRI_SLEEP_STEP_US = 62500;
  localparam int PSRI_SLEEP_STEP_CYC = PSRI_SLEEP_STEP_US / 1000 * PSRI_CLK_FREQ_KHZ
                                     + (PSRI_SLEEP_STEP_US % 1000) * PSRI_CLK_FREQ_KHZ / 1000;

  typedef enum logic [4:0] {
    PSRI_IS_IDLE  = 5'b00001,
    PSRI_IS_RX    = 5'b00010,
    PSRI_IS_ACK   = 5'b00100,
    PSRI_IS_TX    = 5'b01000,
    PSRI_IS_TXACK = 5'b10000
  } psri_i2c_state_t;

  typedef enum logic [3:0] {
    PSRI_CS_IDLE  = 4'b0001,
    PSRI_CS_TEMP  = 4'b0010,
    PSRI_CS_PRESS = 4'b0100,
    PSRI_CS_SLEEP = 4'b1000
  } psri_conv_state_t;

endpackage : psri_pkg

// file: core/psri_sleep_timer.sv
// psri_sleep_timer: waits sleep code times one step, then pulses expired.
// assumes start is a one-cycle pulse and code is stable while it runs.
`timescale 1ns/1ps
`default_nettype none
module psri_sleep_timer
  import psri_pkg::*;
#(
  parameter int STEP_CYC = PSRI_SLEEP_STEP_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [3:0] code,
  output logic            expired
);

  logic [3:0]  steps_r;
  logic [21:0] sub_r;
  logic        run_r;
  wire         step_end = (sub_r == 22'(STEP_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      steps_r <= 4'h0;
      sub_r   <= 22'h000000;
      run_r   <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (start) begin
        steps_r <= code;
        sub_r   <= 22'h000000;
        run_r   <= 1'b1;
      end else if (run_r && steps_r == 4'h0) begin
        run_r   <= 1'b0;
        expired <= 1'b1;
      end else if (run_r) begin
        sub_r <= step_end ? 22'h000000 : sub_r + 22'h000001;
        if (step_end)
          steps_r <= steps_r - 4'h1;
      end
    end
  end

endmodule : psri_sleep_timer
`default_nettype wire

// file: core/psri_conv_seq.sv
// psri_conv_seq: runs temperature then pressure conversions on the front end
// and loops them through the sleep timer in periodic mode.
// assumes the front end answers each request with one done pulse.
`timescale 1ns/1ps
`default_nettype none
module psri_conv_seq
  import psri_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start_req,
  input  wire logic [2:0]  mode,
  input  wire logic        fe_done,
  input  wire logic [23:0] fe_data,
  input  wire logic        timer_expired,
  output logic             fe_req,
  output logic             fe_pressure,
  output logic             timer_start,
  output logic             commit,
  output logic             finish,
  output logic [15:0]      temp_out,
  output logic [23:0]      press_out
);

  psri_conv_state_t st_r;
  logic [15:0]      temp_hold_r;
  wire              mode_ok  = (mode == PSRI_MODE_COMBINED) || (mode == PSRI_MODE_SLEEP);
  wire              periodic = start_req && (mode == PSRI_MODE_SLEEP);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r        <= PSRI_CS_IDLE;
      temp_hold_r <= PSRI_TEMP_RST;
      fe_req      <= 1'b0;
      fe_pressure <= 1'b0;
      timer_start <= 1'b0;
      commit      <= 1'b0;
      finish      <= 1'b0;
      temp_out    <= PSRI_TEMP_RST;
      press_out   <= PSRI_PRESS_RST;
    end else if (ce) begin
      fe_req      <= 1'b0;
      timer_start <= 1'b0;
      commit      <= 1'b0;
      finish      <= 1'b0;
      case (st_r)
        PSRI_CS_IDLE: begin
          // temperature first
          // the start flag clears one cycle after finish; no restart on the stale flag
          if (start_req && mode_ok && !finish) begin
            fe_req      <= 1'b1;
            fe_pressure <= 1'b0;
            st_r        <= PSRI_CS_TEMP;
          end else if (start_req) begin
            finish <= 1'b1;
          end
        end
        PSRI_CS_TEMP: begin
          if (fe_done) begin
            temp_hold_r <= fe_data[15:0];
            fe_req      <= 1'b1;
            fe_pressure <= 1'b1;
            st_r        <= PSRI_CS_PRESS;
          end
        end
        PSRI_CS_PRESS: begin
          if (fe_done) begin
            temp_out  <= temp_hold_r;
            press_out <= fe_data;
            commit    <= 1'b1;
            if (periodic) begin
              timer_start <= 1'b1;
              st_r        <= PSRI_CS_SLEEP;
            end else begin
              finish <= 1'b1;
              st_r   <= PSRI_CS_IDLE;
            end
          end
        end
        PSRI_CS_SLEEP: begin
          if (!periodic) begin
            st_r <= PSRI_CS_IDLE;
          end else if (timer_expired) begin
            fe_req      <= 1'b1;
            fe_pressure <= 1'b0;
            st_r        <= PSRI_CS_TEMP;
          end
        end
        default: st_r <= PSRI_CS_IDLE;
      endcase
    end
  end

endmodule : psri_conv_seq

// file: core/psri_top.sv
// psri_top: serial-bus register interface of a differential pressure sensor:
// two-wire target, register map, conversion control and result formatting.
// assumes scl/sda are already synchronous to sys_clk and the analog front end
// converts on a request/done handshake with results on fe_conv_data.
`timescale 1ns/1ps
`default_nettype none
module psri_top
  import psri_pkg::*;
#(
  parameter int SLEEP_STEP_CYC = PSRI_SLEEP_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             fe_conv_req,
  output logic             fe_conv_pressure,
  input  wire logic        fe_conv_done,
  input  wire logic [23:0] fe_conv_data,
  output logic             regulator_voltage_select,
  output logic             raw_output_select,
  output logic             unsigned_output_select,
  output logic             diag_enable,
  output logic             input_swap,
  output logic [2:0]       pressure_gain_code,
  output logic [7:0]       pressure_gain_factor,
  output logic [2:0]       oversampling_ratio_field,
  output logic [15:0]      oversampling_ratio
);

  // bus line sampling
  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce) begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  wire scl_rise  = scl_in & ~scl_q_r;
  wire scl_fall  = ~scl_in & scl_q_r;
  wire bus_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire bus_stop  = scl_in & scl_q_r & ~sda_q_r & sda_in;

  // serial target state
  psri_i2c_state_t ist_r;
  psri_i2c_state_t ist_nxt;
  logic [3:0]      cnt_r;
  logic [3:0]      cnt_nxt;
  logic [7:0]      sh_r;
  logic [7:0]      sh_nxt;
  logic [1:0]      idx_r;
  logic [1:0]      idx_nxt;
  logic [7:0]      ptr_r;
  logic [7:0]      ptr_nxt;
  logic            go_tx_r;
  logic            go_tx_nxt;
  logic            sda_oe_r;
  logic            sda_oe_nxt;
  logic            wr_stb;
  logic [7:0]      rd_data;

  wire byte_done = scl_fall && (cnt_r == 4'h8);
  wire addr_hit  = (sh_r[7:1] == PSRI_TARGET_ADDR);

  always_comb begin
    ist_nxt   = ist_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    idx_nxt   = idx_r;
    ptr_nxt   = ptr_r;
    go_tx_nxt = go_tx_r;
    wr_stb    = 1'b0;
    if (bus_start) begin
      // repeated start restarts the address phase
      ist_nxt = PSRI_IS_RX;
      cnt_nxt = 4'h0;
      idx_nxt = 2'h0;
    end else if (bus_stop) begin
      ist_nxt = PSRI_IS_IDLE;
    end else begin
      case (ist_r)
        PSRI_IS_IDLE: ist_nxt = PSRI_IS_IDLE;
        PSRI_IS_RX: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_nxt = 4'h0;
            // acknowledge address, register and one data byte
            case (idx_r)
              2'h0: begin
                ist_nxt   = addr_hit ? PSRI_IS_ACK : PSRI_IS_IDLE;
                go_tx_nxt = sh_r[0];
                idx_nxt   = 2'h1;
              end
              2'h1: begin
                ptr_nxt   = sh_r;
                ist_nxt   = PSRI_IS_ACK;
                go_tx_nxt = 1'b0;
                idx_nxt   = 2'h2;
              end
              2'h2: begin
                wr_stb  = 1'b1;
                ist_nxt = PSRI_IS_ACK;
                idx_nxt = 2'h3;
              end
              default: ist_nxt = PSRI_IS_IDLE;
            endcase
          end
        end
        PSRI_IS_ACK: begin
          if (scl_fall) begin
            ist_nxt = go_tx_r ? PSRI_IS_TX : PSRI_IS_RX;
            sh_nxt  = go_tx_r ? rd_data : sh_r;
            cnt_nxt = 4'h0;
          end
        end
        PSRI_IS_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            ist_nxt = PSRI_IS_TXACK;
          end else if (scl_fall) begin
            sh_nxt = {sh_r[6:0], 1'b0};
          end
        end
        PSRI_IS_TXACK: begin
          // master ack asks for the next register, nack ends the read
          if (scl_rise) begin
            go_tx_nxt = ~sda_in;
            ptr_nxt   = sda_in ? ptr_r : ptr_r + 8'h01;
          end else if (scl_fall) begin
            ist_nxt = go_tx_r ? PSRI_IS_TX : PSRI_IS_IDLE;
            sh_nxt  = rd_data;
            cnt_nxt = 4'h0;
          end
        end
        default: ist_nxt = PSRI_IS_IDLE;
      endcase
    end
  end

  // open drain: only ever pull low, never drive high
  assign sda_oe_nxt = (ist_nxt == PSRI_IS_ACK) || ((ist_nxt == PSRI_IS_TX) && !sh_nxt[7]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ist_r    <= PSRI_IS_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      idx_r    <= 2'h0;
      ptr_r    <= 8'h00;
      go_tx_r  <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (ce) begin
      ist_r    <= ist_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      idx_r    <= idx_nxt;
      ptr_r    <= ptr_nxt;
      go_tx_r  <= go_tx_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_r;

  // register file
  logic [7:0]  cmd_r;
  logic [7:0]  cmd_nxt;
  logic [7:0]  syscfg_r;
  logic [7:0]  pcfg_r;
  logic [23:0] press_r;
  logic [15:0] temp_r;
  logic        conv_commit;
  logic        conv_finish;
  logic        timer_start;
  logic        timer_expired;
  logic [15:0] seq_temp;
  logic [23:0] seq_press;

  wire wr_cmd    = wr_stb && (ptr_r == PSRI_OFF_CMD);
  wire wr_syscfg = wr_stb && (ptr_r == PSRI_OFF_SYSCFG);
  wire wr_pcfg   = wr_stb && (ptr_r == PSRI_OFF_PCFG);
  wire [2:0] cmd_mode   = cmd_r[2:0];
  wire [3:0] sleep_code = cmd_r[7:PSRI_CMD_SLEEP_LSB];
  wire       start_flag = cmd_r[PSRI_CMD_START_BIT];

  // self-clear at conversion end, not in sleep mode; a write wins
  always_comb begin
    cmd_nxt = cmd_r;
    if (wr_cmd)
      cmd_nxt = sh_r;
    else if (conv_finish && cmd_mode != PSRI_MODE_SLEEP)
      cmd_nxt[PSRI_CMD_START_BIT] = 1'b0;
  end

  // unsigned format only applies to raw output
  wire fmt_unsigned = syscfg_r[PSRI_SYS_RAW_BIT] & syscfg_r[PSRI_SYS_UNS_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_r    <= PSRI_CMD_RST;
      syscfg_r <= PSRI_SYSCFG_RST;
      pcfg_r   <= PSRI_PCFG_RST;
      press_r  <= PSRI_PRESS_RST;
      temp_r   <= PSRI_TEMP_RST;
    end else if (ce) begin
      cmd_r <= cmd_nxt;
      if (wr_syscfg)
        syscfg_r <= sh_r;
      if (wr_pcfg)
        pcfg_r <= sh_r;
      if (conv_commit) begin
        // sign bit kept at bit 23 unless unsigned is chosen
        press_r <= {seq_press[23] ^ fmt_unsigned, seq_press[22:0]};
        // two's complement temperature, offset binary if unsigned
        temp_r  <= {seq_temp[15] ^ fmt_unsigned, seq_temp[14:0]};
      end
    end
  end

  // pressure bytes, temperature bytes; unmapped offsets read zero
  assign rd_data = (ptr_r == PSRI_OFF_PRESS_HIGH) ? press_r[23:16] :
                   (ptr_r == PSRI_OFF_PRESS_MID)  ? press_r[15:8]  :
                   (ptr_r == PSRI_OFF_PRESS_LOW)  ? press_r[7:0]   :
                   (ptr_r == PSRI_OFF_TEMP_HIGH)  ? temp_r[15:8]   :
                   (ptr_r == PSRI_OFF_TEMP_LOW)   ? temp_r[7:0]    :
                   (ptr_r == PSRI_OFF_CMD)        ? cmd_r          :
                   (ptr_r == PSRI_OFF_SYSCFG)     ? syscfg_r       :
                   (ptr_r == PSRI_OFF_PCFG)       ? pcfg_r         : 8'h00;

  psri_conv_seq u_seq (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .ce            (ce),
    .start_req     (start_flag),
    .mode          (cmd_mode),
    .fe_done       (fe_conv_done),
    .fe_data       (fe_conv_data),
    .timer_expired (timer_expired),
    .fe_req        (fe_conv_req),
    .fe_pressure   (fe_conv_pressure),
    .timer_start   (timer_start),
    .commit        (conv_commit),
    .finish        (conv_finish),
    .temp_out      (seq_temp),
    .press_out     (seq_press)
  );

  // sleep interval from the command nibble
  psri_sleep_timer #(
    .STEP_CYC (SLEEP_STEP_CYC)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .start   (timer_start),
    .code    (sleep_code),
    .expired (timer_expired)
  );

  // front-end configuration outputs
  // regulator level select
  assign regulator_voltage_select = syscfg_r[PSRI_SYS_REG_BIT];
  assign raw_output_select        = syscfg_r[PSRI_SYS_RAW_BIT];
  assign unsigned_output_select   = syscfg_r[PSRI_SYS_UNS_BIT];
  assign diag_enable              = syscfg_r[PSRI_SYS_DIAG_BIT];
  assign input_swap               = pcfg_r[PSRI_PCFG_SWAP_BIT];
  assign pressure_gain_code       = pcfg_r[5:PSRI_PCFG_GAIN_LSB];
  assign pressure_gain_factor     = 8'h01 << pressure_gain_code;
  assign oversampling_ratio_field = pcfg_r[2:0];

  // oversampling ratio lookup; codes 100 and 101 sit below 1024
  assign oversampling_ratio = (oversampling_ratio_field == 3'h0) ? 16'h0400 :
                              (oversampling_ratio_field == 3'h1) ? 16'h0800 :
                              (oversampling_ratio_field == 3'h2) ? 16'h1000 :
                              (oversampling_ratio_field == 3'h3) ? 16'h2000 :
                              (oversampling_ratio_field == 3'h4) ? 16'h0100 :
                              (oversampling_ratio_field == 3'h5) ? 16'h0200 :
                              (oversampling_ratio_field == 3'h6) ? 16'h4000 : 16'h8000;

endmodule : psri_top
`default_nettype wire

// file: sim/psri_top_asserts.sv
// psri_top_asserts: port-level checks of psri_top.
// assumes ce is lowered only while the front end is idle; bound to psri_top from the bench.
`timescale 1ns/1ps
`default_nettype none
module psri_top_asserts
  import psri_pkg::*;
#(
  parameter int SLEEP_STEP_CYC = PSRI_SLEEP_STEP_CYC
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        fe_conv_req,
  input wire logic        fe_conv_pressure,
  input wire logic        fe_conv_done,
  input wire logic [23:0] fe_conv_data,
  input wire logic        regulator_voltage_select,
  input wire logic        raw_output_select,
  input wire logic        unsigned_output_select,
  input wire logic        diag_enable,
  input wire logic        input_swap,
  input wire logic [2:0]  pressure_gain_code,
  input wire logic [7:0]  pressure_gain_factor,
  input wire logic [2:0]  oversampling_ratio_field,
  input wire logic [15:0] oversampling_ratio
);
  localparam logic [15:0] OSR_TAB [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
                                          16'h0100, 16'h0200, 16'h4000, 16'h8000};
  logic pend_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // tracks the single request the front end may hold
  always_ff @(posedge sys_clk) begin
    if (rst) pend_r <= 1'b0;
    else if (fe_conv_req) pend_r <= 1'b1;
    else if (fe_conv_done) pend_r <= 1'b0;
  end

  open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  reset_state_a: assert property ($past(rst) |-> !sda_oe && !fe_conv_req && diag_enable
    && pressure_gain_factor == 8'h01 && oversampling_ratio == 16'h0400) else $error("reset state");
  req_pulse_a: assert property (fe_conv_req |=> !fe_conv_req)
    else $error("request longer than a cycle");
  one_outstanding_a: assert property (fe_conv_req |-> !pend_r)
    else $error("second request outstanding");
  temp_then_press_a: assert property (fe_conv_done && pend_r && !fe_conv_pressure
    |=> fe_conv_req && fe_conv_pressure) else $error("pressure not after temperature");
  gain_map_a: assert property (pressure_gain_factor == (8'h01 << pressure_gain_code))
    else $error("gain factor");
  osr_map_a: assert property (oversampling_ratio == OSR_TAB[oversampling_ratio_field])
    else $error("oversampling ratio");
  sda_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");

  cover property (fe_conv_req && fe_conv_pressure);
  cover property ($rose(sda_oe));
  cover property (input_swap && pressure_gain_code == 3'h7);
endmodule : psri_top_asserts
`default_nettype wire

// file: sim/psri_bus_master.sv
// psri_bus_master: two-wire bus master model for psri_top.
// assumes pull-ups on both lines; the target pulls data low via sda_oe.
`timescale 1ns/1ps
`default_nettype none
module psri_bus_master
  import psri_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  output var logic  scl_in,
  output wire logic sda_in
);
  logic sda_drv = 1'b1;

  // a released line floats to the pull-up level
  assign sda_in = sda_drv & ~sda_oe;
  initial scl_in = 1'b1;

  task automatic tick;
    repeat (3) @(posedge sys_clk);
  endtask : tick

  // data changes only while scl is low; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    scl_in <= 1'b0;
    tick();
    sda_drv <= b;
    tick();
    scl_in <= 1'b1;
    tick();
    r = sda_in;
  endtask : bit_io

  // start is (1, 0), stop is (0, 1)
  task automatic cond(input logic a, input logic b);
    scl_in <= 1'b0;
    tick();
    sda_drv <= a;
    tick();
    scl_in <= 1'b1;
    tick();
    sda_drv <= b;
    tick();
  endtask : cond

  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q,
                       output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(m, k);
  endtask : xbyte

  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    cond(1'b1, 1'b0);
    xbyte({a, 1'b0}, 1'b1, q, k0);
    xbyte(r, 1'b1, q, k1);
    xbyte(d, 1'b1, q, k2);
    cond(1'b0, 1'b1);
    ok = !(k0 | k1 | k2);
  endtask : wr

  task automatic rd(input logic [7:0] r, output logic [7:0] q);
    logic k;
    cond(1'b1, 1'b0);
    xbyte({PSRI_TARGET_ADDR, 1'b0}, 1'b1, q, k);
    xbyte(r, 1'b1, q, k);
    cond(1'b1, 1'b0);
    xbyte({PSRI_TARGET_ADDR, 1'b1}, 1'b1, q, k);
    xbyte(8'hff, 1'b1, q, k);
    cond(1'b0, 1'b1);
  endtask : rd
endmodule : psri_bus_master
`default_nettype wire

// file: sim/psri_tb_top.sv
// psri_tb_top: self-checking bench with bus master, front-end and result models.
// assumes the sleep step is shortened to 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module psri_tb_top
  import psri_pkg::*;
  ;
  localparam int STEP = 8;
  localparam logic [15:0] OSR [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
                                     16'h0100, 16'h0200, 16'h4000, 16'h8000};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        fe_conv_done = 1'b0;
  logic [23:0] fe_conv_data = 24'h0;
  logic        scl_in, sda_in, sda_out, sda_oe, fe_conv_req, fe_conv_pressure;
  logic        reg_v, raw_s, uns_s, diag, swap;
  logic [2:0]  g_code, o_field;
  logic [7:0]  g_fac;
  logic [15:0] o_ratio, tmp_t, exp_t;
  logic [23:0] exp_p;
  logic        uns_on = 1'b0;
  int          n_errors = 0, total_checks = 0, n_req = 0, n_conv = 0;
  int          cyc = 0, t_done = 0, gap = 0, fe_wait = 0;

  always #12.5 sys_clk = ~sys_clk;

  psri_top #(.SLEEP_STEP_CYC(STEP)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .fe_conv_req(fe_conv_req),
    .fe_conv_pressure(fe_conv_pressure), .fe_conv_done(fe_conv_done),
    .fe_conv_data(fe_conv_data), .regulator_voltage_select(reg_v),
    .raw_output_select(raw_s), .unsigned_output_select(uns_s), .diag_enable(diag),
    .input_swap(swap), .pressure_gain_code(g_code), .pressure_gain_factor(g_fac),
    .oversampling_ratio_field(o_field), .oversampling_ratio(o_ratio));
  psri_bus_master i_mst (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  // front end answers after 1..12 cycles; result model follows each pair
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    fe_conv_done <= 1'b0;
    if (fe_conv_done && fe_conv_pressure) begin
      exp_p <= fe_conv_data;
      exp_t <= tmp_t;
      n_conv <= n_conv + 1;
      t_done <= cyc;
    end else if (fe_conv_done) tmp_t <= fe_conv_data[15:0];
    if (fe_conv_req) begin
      n_req <= n_req + 1;
      fe_wait <= $urandom_range(12, 1);
      if (!fe_conv_pressure) gap <= cyc - t_done;
    end else if (fe_wait > 1) fe_wait <= fe_wait - 1;
    else if (fe_wait == 1) begin
      fe_wait <= 0;
      fe_conv_done <= 1'b1;
      fe_conv_data <= 24'($urandom);
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrc(input logic [7:0] off, input logic [7:0] d);
    logic ok;
    i_mst.wr(PSRI_TARGET_ADDR, off, d, ok);
    chk(24'(ok), 24'h1);
  endtask : wrc

  task automatic rdchk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] q;
    i_mst.rd(off, q);
    chk(24'(q), 24'(exp));
  endtask : rdchk

  // unsigned output only shows with raw data selected
  task automatic conv(input logic [7:0] cfg);
    logic [7:0] b [5];
    logic [7:0] q;
    int         n;
    wrc(PSRI_OFF_SYSCFG, cfg);
    uns_on = cfg[2] & cfg[1];
    n = n_conv;
    wrc(PSRI_OFF_CMD, 8'h0a);
    q = 8'hff;
    // a fixed wait stands in for the 20 ms; 40 cycles cover the slowest model conversion
    if (cfg[7]) repeat (40) @(posedge sys_clk);
    else for (int k = 0; k < 20 && q[3] !== 1'b0; k++) i_mst.rd(PSRI_OFF_CMD, q);
    for (int k = 0; k < 5; k++) i_mst.rd(PSRI_OFF_PRESS_HIGH + 8'(k), b[k]);
    if (cfg[7]) i_mst.rd(PSRI_OFF_CMD, q);
    chk(24'(q), 24'h02);
    chk(24'(n_conv - n), 24'h1);
    chk({b[0], b[1], b[2]}, exp_p ^ {uns_on, 23'h0});
    chk({8'h0, b[3], b[4]}, {8'h0, exp_t ^ {uns_on, 15'h0}});
  endtask : conv

  task automatic conclude;
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end

  initial begin
    logic [7:0] d, s;
    logic       ok;
    int         n;
    void'($urandom(32'hb2a9));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(24'(diag), 24'h1);
    rdchk(PSRI_OFF_CMD, PSRI_CMD_RST);
    rdchk(PSRI_OFF_SYSCFG, PSRI_SYSCFG_RST);
    rdchk(PSRI_OFF_PCFG, PSRI_PCFG_RST);
    for (int k = 0; k < 5; k++) rdchk(PSRI_OFF_PRESS_HIGH + 8'(k), 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = {i[0], 1'b0, i[2:0], 3'(7 - i)};
      wrc(PSRI_OFF_PCFG, d);
      chk(24'(g_fac), 24'(1 << i));
      chk(24'(o_ratio), 24'(OSR[7 - i]));
      chk(24'(swap), 24'(i[0]));
      chk(24'({g_code, o_field}), 24'(d[5:0]));
      s = 8'($urandom);
      wrc(PSRI_OFF_SYSCFG, s);
      chk(24'({reg_v, uns_s, raw_s, diag}), 24'(s[3:0]));
      rdchk(PSRI_OFF_PCFG, d);
      rdchk(PSRI_OFF_SYSCFG, s);
    end
    conv(8'h01);
    conv(8'h87);
    wrc(PSRI_OFF_CMD, 8'h2b);
    n = n_conv;
    for (int k = 0; k < 3000 && n_conv < n + 3; k++) @(posedge sys_clk);
    rdchk(PSRI_OFF_CMD, 8'h2b);
    chk(24'(gap >= 2 * STEP && gap <= 2 * STEP + 10), 24'h1);
    wrc(PSRI_OFF_CMD, 8'h00);
    repeat (100) @(posedge sys_clk);
    n = n_req;
    i_mst.wr(7'h3c, PSRI_OFF_CMD, 8'h0a, ok);
    chk(24'(ok), 24'h0);
    wrc(PSRI_OFF_CMD, 8'h09);
    repeat (20) @(posedge sys_clk);
    chk(24'(n_req - n), 24'h0);
    rdchk(PSRI_OFF_CMD, 8'h01);
    wrc(PSRI_OFF_PRESS_HIGH, ~exp_p[23:16]);
    rdchk(PSRI_OFF_PRESS_HIGH, exp_p[23:16] ^ {uns_on, 7'h0});
    rdchk(8'h40, 8'h00);
    // a frozen device neither acknowledges nor takes the write
    ce <= 1'b0;
    i_mst.wr(PSRI_TARGET_ADDR, PSRI_OFF_PCFG, 8'h5a, ok);
    chk(24'(ok), 24'h0);
    ce <= 1'b1;
    rdchk(PSRI_OFF_PCFG, d);
    conclude();
  end
endmodule : psri_tb_top

bind psri_top psri_top_asserts #(.SLEEP_STEP_CYC(SLEEP_STEP_CYC)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .fe_conv_req(fe_conv_req),
  .fe_conv_pressure(fe_conv_pressure), .fe_conv_done(fe_conv_done),
  .fe_conv_data(fe_conv_data), .regulator_voltage_select(regulator_voltage_select),
  .raw_output_select(raw_output_select), .unsigned_output_select(unsigned_output_select),
  .diag_enable(diag_enable), .input_swap(input_swap),
  .pressure_gain_code(pressure_gain_code), .pressure_gain_factor(pressure_gain_factor),
  .oversampling_ratio_field(oversampling_ratio_field),
  .oversampling_ratio(oversampling_ratio));
`default_nettype wire
